/* core/pdvm_power_monitor.v */
// pdvm_power_monitor.v: power-down sequencer, undervoltage detector control
// and brownout reset, with an axi4-lite slave for the control register.
// assumes one 10 mhz clock; cpu handshake signals are on the same clock,
// comparator inputs and oscillator tick come from outside and are synchronised.
`timescale 1ns/1ps
`include "pdvm_map.vh"
module pdvm_power_monitor
(
    input  wire        i_clk,
    input  wire        i_rstn,
    // axi4-lite slave
    input  wire [11:0] i_awaddr,
    input  wire        i_awvalid,
    output wire        o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output wire        o_wready,
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    input  wire [11:0] i_araddr,
    input  wire        i_arvalid,
    output wire        o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    // cpu core side
    input  wire        i_sleep_op,       // pulse: sleep opcode executed
    input  wire        i_stop_op,        // pulse: stop opcode executed
    input  wire        i_irq_pending,    // any interrupt request
    input  wire        i_irq_disable,    // cpu interrupt-disable flag
    input  wire        i_osc_tick,       // main oscillator edge, async
    input  wire        i_uvd_cmp,        // undervoltage comparator, async
    input  wire        i_brownout_cmp,   // brownout comparator, async
    output reg         o_cpu_halt,       // cpu holds pc and all state
    output reg         o_wake_vector,    // pulse: take interrupt vector
    output reg         o_wake_resume,    // pulse: resume at next opcode
    output reg         o_main_osc_en,    // main oscillator running
    output reg         o_cpu_clk_en,     // cpu clock gate
    output reg         o_timer_main_en,  // main-clocked timers and tone gen
    output reg         o_uvd_enable,     // analog detector enable
    output reg         o_reset_pin_n,    // brownout reset output, low active
    output wire [1:0]  o_pwr_state       // current power state
);

    // power states
    localparam [1:0] ST_RUN   = 2'h0;
    localparam [1:0] ST_LIGHT = 2'h1;
    localparam [1:0] ST_DEEP  = 2'h2;
    localparam [1:0] ST_HALT  = 2'h3;
    localparam [1:0] PH_IDLE  = 2'h0;   // no warm-up in progress
    localparam [1:0] PH_WARM  = 2'h1;   // counting oscillator ticks
    localparam [1:0] PH_BOOT  = 2'h2;   // warm-up after reset

    reg  [7:0]  ctrl_r;                 // control register bits
    reg  [1:0]  state_r;                // power state
    reg  [1:0]  phase_r;                // warm-up phase
    reg  [8:0]  warm_cnt_r;             // oscillator ticks left
    reg         wake_irq_r;             // wake was unmasked interrupt
    reg  [5:0]  uvd_cnt_r;              // settle counter
    reg         uvd_read_r;             // first read seen since enable
    reg  [2:0]  tick_s_r;               // osc tick sync and edge history
    reg  [1:0]  uvd_s_r;                // comparator synchroniser
    reg  [1:0]  bo_s_r;                 // brownout synchroniser
    reg         aw_hold_r;              // write address taken
    reg         w_hold_r;               // write data taken
    reg  [11:0] awaddr_r;               // held write address
    reg  [7:0]  wdata_r;                // held write byte
    reg         wstrb_r;                // held lane 0 strobe
    wire        tick_edge;              // one osc tick seen
    wire        wr_go;                  // write completes this cycle
    wire        wr_hit;                 // write hits control register
    wire        rd_go;                  // read taken this cycle
    wire [7:0]  rd_view;                // read image of control register
    wire [8:0]  warm_len;               // selected warm-up length
    wire [11:0] ctrl_addr = `PDVM_CTRL_OFFSET;     // control register byte address
    wire [31:0] settle_cyc = `PDVM_UVD_SETTLE_CYC; // integer count, only low six bits are used

    assign o_pwr_state = state_r;

    // synchronisers: first flop feeds only the second
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tick_s_r <= 3'h0;
            uvd_s_r  <= 2'h0;
            bo_s_r   <= 2'h0;
        end
        else
        begin
            tick_s_r <= {tick_s_r[1:0], i_osc_tick};
            uvd_s_r  <= {uvd_s_r[0], i_uvd_cmp};
            bo_s_r   <= {bo_s_r[0], i_brownout_cmp};
        end
    end
    assign tick_edge = tick_s_r[1] & ~tick_s_r[2];

    // brownout reset: always on, no control bit can mask it
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_reset_pin_n <= 1'b1;
        else
            o_reset_pin_n <= ~bo_s_r[1];
    end

    // axi4-lite handshakes: take each channel once, answer after both
    assign o_awready = ~aw_hold_r & ~o_bvalid;
    assign o_wready  = ~w_hold_r & ~o_bvalid;
    assign o_arready = ~o_rvalid;
    assign wr_go     = aw_hold_r & w_hold_r & ~o_bvalid;
    assign wr_hit    = (awaddr_r[11:2] == ctrl_addr[11:2]);
    assign rd_go     = i_arvalid & o_arready;
    assign warm_len  = ctrl_r[`PDVM_BIT_WSHORT] ? `PDVM_WARM_SHORT
                                                : `PDVM_WARM_LONG;
    // bit 0 reads the comparator only once settled and pre-read; bit 1 reads 1
    assign rd_view   = {ctrl_r[7:2], 1'b1,
                        uvd_s_r[1] & (uvd_cnt_r == 6'h0) & uvd_read_r};

    // write channel capture
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= 12'h000;
            wdata_r   <= 8'h00;
            wstrb_r   <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `PDVM_RESP_OKAY;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= i_awaddr;
            end
            if (i_wvalid && o_wready)
            begin
                w_hold_r <= 1'b1;
                wdata_r  <= i_wdata[7:0];
                wstrb_r  <= i_wstrb[0];
            end
            if (wr_go)
            begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                o_bvalid  <= 1'b1;
                o_bresp   <= wr_hit ? `PDVM_RESP_OKAY : `PDVM_RESP_SLVERR;
            end
            else if (o_bvalid && i_bready)
                o_bvalid <= 1'b0;
        end
    end

    // read channel: one cycle after address
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= `PDVM_RESP_OKAY;
        end
        else if (rd_go)
        begin
            o_rvalid <= 1'b1;
            if (i_araddr[11:2] == ctrl_addr[11:2])
            begin
                o_rdata <= {24'h000000, rd_view};
                o_rresp <= `PDVM_RESP_OKAY;
            end
            else
            begin
                o_rdata <= 32'h0000_0000;
                o_rresp <= `PDVM_RESP_SLVERR;
            end
        end
        else if (o_rvalid && i_rready)
            o_rvalid <= 1'b0;
    end

    // control register and undervoltage detector sequencing
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ctrl_r       <= `PDVM_CTRL_RESET;
            uvd_cnt_r    <= 6'h0;
            uvd_read_r   <= 1'b0;
            o_uvd_enable <= 1'b0;
        end
        else
        begin
            if (wr_go && wr_hit && wstrb_r)
            begin
                ctrl_r       <= {wdata_r[7:2], 2'h0};
                o_uvd_enable <= wdata_r[`PDVM_BIT_UVD];
                // settle time restarts only on a write that turns the detector on
                if (wdata_r[`PDVM_BIT_UVD] && !o_uvd_enable)
                begin
                    uvd_cnt_r  <= settle_cyc[5:0];
                    uvd_read_r <= 1'b0;
                end
            end
            else if (uvd_cnt_r != 6'h0)
                uvd_cnt_r <= uvd_cnt_r - 6'h1;
            // first read after enable arms the stable result
            if (rd_go && o_uvd_enable && (i_araddr[11:2] == ctrl_addr[11:2]))
                uvd_read_r <= 1'b1;
        end
    end

    // power-down state machine; the cpu keeps all state while halted
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_r       <= ST_RUN;
            phase_r       <= PH_BOOT;       // reset always warms up
            warm_cnt_r    <= `PDVM_WARM_LONG;
            wake_irq_r    <= 1'b0;
            o_wake_vector <= 1'b0;
            o_wake_resume <= 1'b0;
        end
        else
        begin
            o_wake_vector <= 1'b0;
            o_wake_resume <= 1'b0;
            case (state_r)
                ST_RUN:
                begin
                    if (phase_r == PH_BOOT)
                    begin
                        // count ticks of the now running oscillator
                        if (tick_edge)
                            warm_cnt_r <= warm_cnt_r - 9'h1;
                        if (tick_edge && warm_cnt_r == 9'h1)
                            phase_r <= PH_IDLE;
                    end
                    else if (i_stop_op)
                        state_r <= ST_HALT;
                    else if (i_sleep_op)
                        state_r <= ctrl_r[`PDVM_BIT_DEPTH] ? ST_DEEP
                                                            : ST_LIGHT;
                end
                ST_LIGHT:
                begin
                    // masked or not, any request wakes
                    if (i_irq_pending)
                    begin
                        state_r       <= ST_RUN;
                        o_wake_vector <= ~i_irq_disable;
                        o_wake_resume <= i_irq_disable;
                    end
                end
                ST_DEEP:
                begin
                    if (phase_r == PH_IDLE && i_irq_pending)
                    begin
                        phase_r    <= PH_WARM;
                        warm_cnt_r <= warm_len;
                        wake_irq_r <= ~i_irq_disable;
                    end
                    else if (phase_r == PH_WARM)
                    begin
                        if (tick_edge)
                            warm_cnt_r <= warm_cnt_r - 9'h1;
                        if (tick_edge && warm_cnt_r == 9'h1)
                        begin
                            phase_r       <= PH_IDLE;
                            state_r       <= ST_RUN;
                            o_wake_vector <= wake_irq_r;
                            o_wake_resume <= ~wake_irq_r;
                        end
                    end
                end
                ST_HALT:
                    state_r <= ST_HALT;      // interrupts ignored
                default:
                    state_r <= ST_RUN;
            endcase
        end
    end

    // clock gating outputs from the settled state
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_cpu_halt      <= 1'b1;
            o_main_osc_en   <= 1'b1;
            o_cpu_clk_en    <= 1'b0;
            o_timer_main_en <= 1'b1;
        end
        else
        begin
            // cpu frozen in any power-down, pc and registers kept
            o_cpu_halt    <= (state_r != ST_RUN) || (phase_r == PH_BOOT);
            o_cpu_clk_en  <= (state_r == ST_RUN) && (phase_r != PH_BOOT);
            // main osc off in deep and halt unless warming up
            o_main_osc_en <= (state_r == ST_RUN) || (state_r == ST_LIGHT) ||
                             (phase_r == PH_WARM);
            // main-clocked timers run only in run and light sleep
            o_timer_main_en <= (state_r == ST_RUN) || (state_r == ST_LIGHT);
        end
    end

endmodule // pdvm_power_monitor

/* core/pdvm_map.vh */
// pdvm_map.vh: offsets, field positions, reset values and timing counts
// for the power-down and voltage monitor block; definitions only.
`ifndef PDVM_MAP_VH
`define PDVM_MAP_VH
`define PDVM_CTRL_OFFSET     12'h030
`define PDVM_CTRL_RESET      8'h00
`define PDVM_BIT_UVD         0
`define PDVM_BIT_DEPTH       2
`define PDVM_BIT_WSHORT      3
`define PDVM_BIT_CLKSRC      7
`define PDVM_WARM_SHORT      9'h010
`define PDVM_WARM_LONG       9'h100
`define PDVM_CLK_HZ          10000000
`define PDVM_UVD_SETTLE_NS   3000
`define PDVM_UVD_SETTLE_CYC  ((`PDVM_UVD_SETTLE_NS * (`PDVM_CLK_HZ / 1000000) + 999) / 1000)
`define PDVM_RESP_OKAY       2'h0
`define PDVM_RESP_SLVERR     2'h2
`endif

/* tb/pdvm_power_monitor_assertions.sv */
// pdvm_power_monitor_assertions.sv: port-level checks of the power monitor
// assumes one clock, async active-low reset; bound into the design top
`timescale 1ns/1ps
module pdvm_checker
(
    input wire       i_clk,
    input wire       i_rstn,
    input wire       i_awvalid,
    input wire       o_awready,
    input wire       i_wvalid,
    input wire       o_wready,
    input wire       o_bvalid,
    input wire       i_bready,
    input wire       i_arvalid,
    input wire       o_arready,
    input wire       o_rvalid,
    input wire       i_sleep_op,
    input wire       i_stop_op,
    input wire       i_irq_pending,
    input wire       i_irq_disable,
    input wire       i_brownout_cmp,
    input wire       o_cpu_halt,
    input wire       o_wake_vector,
    input wire       o_wake_resume,
    input wire       o_cpu_clk_en,
    input wire       o_reset_pin_n,
    input wire [1:0] o_pwr_state
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // opcodes only count once boot warm-up has let the cpu run
    wire run_ok = (o_pwr_state == 2'h0) && !o_cpu_halt;
    sequence s_write_taken; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
    sequence s_read_taken; i_arvalid && o_arready; endsequence
    sequence s_light_irq; o_pwr_state == 2'h1 && i_irq_pending; endsequence
    a_write_answer: assert property (s_write_taken |-> ##[1:2] o_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_read_taken |=> o_rvalid)
        else $error("read data late");
    a_sleep_entry: assert property (run_ok && i_sleep_op && !i_stop_op |=> o_pwr_state inside {2'h1, 2'h2})
        else $error("sleep opcode ignored");
    a_stop_entry: assert property (run_ok && i_stop_op |=> o_pwr_state == 2'h3)
        else $error("stop opcode ignored");
    a_halt_only_reset: assert property (o_pwr_state == 2'h3 |=> $stable(o_pwr_state))
        else $error("halt left without reset");
    a_halt_gated: assert property ($past(o_pwr_state) == 2'h3 && o_pwr_state == 2'h3 |-> o_cpu_halt && !o_cpu_clk_en)
        else $error("cpu clock runs in halt");
    a_masked_wake: assert property (s_light_irq ##0 i_irq_disable |-> ##[1:2] o_wake_resume)
        else $error("masked wake missing");
    a_open_wake: assert property (s_light_irq ##0 !i_irq_disable |-> ##[1:2] o_wake_vector)
        else $error("vector fetch missing");
    a_brownout_low: assert property (i_brownout_cmp [*5] |-> !o_reset_pin_n)
        else $error("brownout pin not low");
endmodule // pdvm_checker
bind pdvm_power_monitor pdvm_checker pdvm_checker_inst (.i_clk, .i_rstn, .i_awvalid, .o_awready,
    .i_wvalid, .o_wready, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rvalid, .i_sleep_op,
    .i_stop_op, .i_irq_pending, .i_irq_disable, .i_brownout_cmp, .o_cpu_halt, .o_wake_vector,
    .o_wake_resume, .o_cpu_clk_en, .o_reset_pin_n, .o_pwr_state);

/* tb/pdvm_cpu_model.sv */
// pdvm_cpu_model.sv: behavioural cpu interrupt source and main oscillator
// assumes the bench pulses i_raise_irq; counts wake pulses for the bench
`timescale 1ns/1ps
module pdvm_cpu_model
(
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_raise_irq,   // bench asks for an interrupt
    input  wire logic i_main_osc_en,
    input  wire logic i_wake_vector,
    input  wire logic i_wake_resume,
    output logic      o_irq_pending,
    output logic      o_osc_tick,
    output int        o_vectors,     // vector fetches seen
    output int        o_resumes      // plain resumes seen
);
    // 260 ns period, unrelated to i_clk; stands still while gated off
    initial
    begin
        o_osc_tick = 1'h0;
        forever #130 if (i_main_osc_en === 1'h1) o_osc_tick = ~o_osc_tick;
    end
    // request holds until the core is woken, so a slow wake is still seen
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_irq_pending <= 1'h0;
        else if (i_raise_irq)
            o_irq_pending <= 1'h1;
        else if (i_wake_vector || i_wake_resume)
            o_irq_pending <= 1'h0;
    end
    // tally how the core was released
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_vectors <= 0;
            o_resumes <= 0;
        end
        else
        begin
            o_vectors <= o_vectors + (i_wake_vector === 1'h1);
            o_resumes <= o_resumes + (i_wake_resume === 1'h1);
        end
    end
endmodule // pdvm_cpu_model

/* tb/pdvm_power_monitor_tb_top.sv */
// pdvm_power_monitor_tb_top.sv: directed bench over the axi4-lite port
// assumes the cpu model drives interrupts and the oscillator tick
`timescale 1ns/1ps
module pdvm_power_monitor_tb_top;
    logic        i_clk = '0, i_rstn = '0, raise = '0;
    logic [11:0] i_awaddr = '0, i_araddr = '0;
    logic [31:0] i_wdata = '0;
    logic [3:0]  i_wstrb = 4'h1;
    logic        i_awvalid = '0, i_wvalid = '0, i_bready = '0, i_arvalid = '0, i_rready = '0;
    logic        i_sleep_op = '0, i_stop_op = '0, i_irq_disable = '0;
    logic        i_uvd_cmp = '1, i_brownout_cmp = '0;
    wire         i_irq_pending, i_osc_tick, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire [1:0]   o_bresp, o_rresp, o_pwr_state;
    wire [31:0]  o_rdata;
    wire         o_cpu_halt, o_wake_vector, o_wake_resume, o_main_osc_en, o_cpu_clk_en;
    wire         o_timer_main_en, o_uvd_enable, o_reset_pin_n;
    int          fails = 0, total_checks = 0, cyc = 0, c, nv, nr;
    pdvm_power_monitor pdvm_power_monitor_inst (.i_clk, .i_rstn, .i_awaddr, .i_awvalid, .o_awready,
        .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
        .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_sleep_op, .i_stop_op,
        .i_irq_pending, .i_irq_disable, .i_osc_tick, .i_uvd_cmp, .i_brownout_cmp, .o_cpu_halt,
        .o_wake_vector, .o_wake_resume, .o_main_osc_en, .o_cpu_clk_en, .o_timer_main_en,
        .o_uvd_enable, .o_reset_pin_n, .o_pwr_state);
    pdvm_cpu_model pdvm_cpu_model_inst (.i_clk, .i_rstn, .i_raise_irq(raise),
        .i_main_osc_en(o_main_osc_en), .i_wake_vector(o_wake_vector),
        .i_wake_resume(o_wake_resume), .o_irq_pending(i_irq_pending), .o_osc_tick(i_osc_tick),
        .o_vectors(nv), .o_resumes(nr));
    always #50 i_clk = ~i_clk;
    // the run needs about 2200 cycles; a hang is cut off well past that
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            $display("BAD %0t timeout", $time);
            fails++;
            print_verdict;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // one write: address and data offered together, each dropped once taken
    task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= {24'h0, d};
        i_awvalid <= '1;
        i_wvalid <= '1;
        i_bready <= '1;
        // no cycle budget here: only the bench timeout ends a stuck wait
        do
        begin
            @(posedge i_clk);
            if (i_awvalid && o_awready) i_awvalid <= '0;
            if (i_wvalid && o_wready) i_wvalid <= '0;
        end
        while (o_bvalid !== 1'h1);
        i_bready <= '0;
        chk(32'(o_bresp), 32'(e));
    endtask
    // one read; data and response taken at the edge rvalid is seen
    task automatic axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= '1;
        i_rready <= '1;
        do
        begin
            @(posedge i_clk);
            if (i_arvalid && o_arready) i_arvalid <= '0;
        end
        while (o_rvalid !== 1'h1);
        i_rready <= '0;
        chk(o_rdata, e);
        chk(32'(o_rresp), 32'(r));
    endtask
    // one-cycle opcode pulse: sleep when s is high, stop otherwise
    task automatic op(input logic s);
        @(posedge i_clk);
        i_sleep_op <= s;
        i_stop_op <= !s;
        @(posedge i_clk);
        i_sleep_op <= '0;
        i_stop_op <= '0;
        tick(3);
    endtask
    // raise an interrupt when r is high, then count clocks until the cpu runs again
    task automatic wake(input logic r);
        if (r)
        begin
            @(posedge i_clk);
            raise <= '1;
            @(posedge i_clk);
            raise <= '0;
        end
        c = 0;
        do
        begin
            @(posedge i_clk);
            c++;
        end
        while ((o_pwr_state !== 2'h0 || o_cpu_halt !== 1'h0) && c < 3000);
        tick(2);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        tick(2);
        i_rstn <= '1;
        wake(1'h0);
        chk(32'(c >= 650 && c < 800), 1);
        axr(12'h030, 32'h2, 2'h0);
        axr(12'h034, 32'h0, 2'h2);
        axw(12'h034, 8'hff, 2'h2);
        // the refused write must leave the control register untouched
        axr(12'h030, 32'h2, 2'h0);
        axw(12'h030, 8'h01, 2'h0);
        chk(32'(o_uvd_enable), 1);
        axr(12'h030, 32'h2, 2'h0);
        // second read still inside the settle time: result held at 0
        axr(12'h030, 32'h2, 2'h0);
        tick(30);
        axr(12'h030, 32'h3, 2'h0);
        i_uvd_cmp <= '0;
        tick(4);
        axr(12'h030, 32'h2, 2'h0);
        axw(12'h030, 8'h00, 2'h0);
        chk(32'(o_uvd_enable), 0);
        // light sleep, first with the interrupt masked, then open
        for (int m = 1; m >= 0; m--)
        begin
            i_irq_disable <= m[0];
            op(1'h1);
            chk(32'({o_pwr_state, o_cpu_halt, o_main_osc_en, o_timer_main_en}), 32'hf);
            wake(1'h1);
            chk(32'(nr), 1);
            chk(32'(nv), 32'(1 - m));
        end
        // deep sleep with short then long warm-up
        for (int s = 1; s >= 0; s--)
        begin
            axw(12'h030, s ? 8'h0c : 8'h04, 2'h0);
            op(1'h1);
            chk(32'({o_pwr_state, o_cpu_clk_en, o_timer_main_en}), 32'h8);
            wake(1'h1);
            chk(32'(s ? (c >= 38 && c < 120) : (c >= 650 && c < 800)), 1);
            axr(12'h030, s ? 32'he : 32'h6, 2'h0);
        end
        chk(32'(nv), 3);
        op(1'h0);
        @(posedge i_clk);
        raise <= '1;
        tick(20);
        chk(32'({o_pwr_state, o_cpu_halt, o_cpu_clk_en}), 32'he);
        i_brownout_cmp <= '1;
        tick(6);
        chk(32'(o_reset_pin_n), 0);
        i_brownout_cmp <= '0;
        tick(6);
        chk(32'(o_reset_pin_n), 1);
        raise <= '0;
        i_rstn <= '0;
        tick(2);
        i_rstn <= '1;
        wake(1'h0);
        chk(32'(c >= 650 && c < 800), 1);
        print_verdict;
    end
endmodule // pdvm_power_monitor_tb_top
